// ==== src/bsb_pkg.sv ====
// Shared constants and types for the branch, skip and bit-operation unit.
// Assumes one core clock; all users reference items as bsb_pkg::name.
package bsb_pkg;

    // ========================================
    // Widths
    localparam int PC_W   = 10;
    localparam int DATA_W = 8;
    localparam int OFS_W  = 7;
    localparam int CNT_W  = 2;

    // ========================================
    // Status word bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ========================================
    // Cycle counts
    localparam logic [CNT_W-1:0] CYC_PLAIN    = 2'h1;
    localparam logic [CNT_W-1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [CNT_W-1:0] CYC_SKIP_TWO = 2'h3;
    localparam logic [CNT_W-1:0] CYC_BR_TAKEN = 2'h2;
    localparam logic [CNT_W-1:0] CYC_IO_BIT   = 2'h2;
    localparam logic [CNT_W-1:0] CYC_SHIFT    = 2'h1;

    // ========================================
    // Reset values
    localparam logic [PC_W-1:0]   PC_RST   = 10'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_RST  = 2'h0;

    // ========================================
    // Operation codes
    typedef enum logic [4:0] {
        skip_if_reg_bit_zero   = 5'b00000,
        skip_if_reg_bit_one    = 5'b00001,
        skip_if_io_bit_zero    = 5'b00010,
        skip_if_io_bit_one     = 5'b00011,
        branch_on_flag_one     = 5'b00100,
        branch_on_flag_zero    = 5'b00101,
        branch_equal           = 5'b00110,
        branch_not_equal       = 5'b00111,
        branch_carry_one       = 5'b01000,
        branch_carry_zero      = 5'b01001,
        branch_same_or_higher  = 5'b01010,
        branch_lower           = 5'b01011,
        branch_minus           = 5'b01100,
        branch_plus            = 5'b01101,
        branch_signed_ge       = 5'b01110,
        branch_signed_lt       = 5'b01111,
        branch_half_carry_one  = 5'b10000,
        branch_half_carry_zero = 5'b10001,
        branch_transfer_one    = 5'b10010,
        branch_transfer_zero   = 5'b10011,
        branch_overflow_one    = 5'b10100,
        branch_overflow_zero   = 5'b10101,
        branch_irq_enabled     = 5'b10110,
        branch_irq_disabled    = 5'b10111,
        io_bit_force_one       = 5'b11000,
        io_bit_force_zero      = 5'b11001,
        logic_shift_up         = 5'b11010,
        logic_shift_down       = 5'b11011
    } bsb_op_type;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } bsb_state_type;

endpackage

// ==== src/bsb_cond.sv ====
// Condition evaluator: decides whether a skip or branch is taken.
// Purely combinational; inputs come from logic on the core clock.
`timescale 1ns/1ns
module bsb_cond
(
    input  wire logic [4:0]              op_i,
    input  wire logic [2:0]              bit_sel_i,
    input  wire logic [bsb_pkg::DATA_W-1:0] reg_data_i,
    input  wire logic [bsb_pkg::DATA_W-1:0] io_data_i,
    input  wire logic [bsb_pkg::DATA_W-1:0] status_word_i,
    output logic                         skip_o,
    output logic                         branch_o
);

    // ========================================
    // Helpers
    function automatic logic pick_bit(input logic [7:0] v,
                                      input logic [2:0] b);
        pick_bit = v[b];
    endfunction

    logic fc;
    logic fz;
    logic fn;
    logic fv;
    logic fh;
    logic ft;
    logic fi;

    assign fc = status_word_i[bsb_pkg::FLAG_C];
    assign fz = status_word_i[bsb_pkg::FLAG_Z];
    assign fn = status_word_i[bsb_pkg::FLAG_N];
    assign fv = status_word_i[bsb_pkg::FLAG_V];
    assign fh = status_word_i[bsb_pkg::FLAG_H];
    assign ft = status_word_i[bsb_pkg::FLAG_T];
    assign fi = status_word_i[bsb_pkg::FLAG_I];

    // ========================================
    // Decision
    always_comb
    begin
        skip_o   = 1'b0;
        branch_o = 1'b0;
        unique case (op_i)
            bsb_pkg::skip_if_reg_bit_zero:
                skip_o = ~pick_bit(reg_data_i, bit_sel_i);
            bsb_pkg::skip_if_reg_bit_one:
                skip_o = pick_bit(reg_data_i, bit_sel_i);
            bsb_pkg::skip_if_io_bit_zero:
                skip_o = ~pick_bit(io_data_i, bit_sel_i);
            bsb_pkg::skip_if_io_bit_one:
                skip_o = pick_bit(io_data_i, bit_sel_i);
            bsb_pkg::branch_on_flag_one:
                branch_o = pick_bit(status_word_i, bit_sel_i);
            bsb_pkg::branch_on_flag_zero:
                branch_o = ~pick_bit(status_word_i, bit_sel_i);
            bsb_pkg::branch_equal:           branch_o = fz;
            bsb_pkg::branch_not_equal:       branch_o = ~fz;
            bsb_pkg::branch_carry_one:       branch_o = fc;
            bsb_pkg::branch_lower:           branch_o = fc;
            bsb_pkg::branch_carry_zero:      branch_o = ~fc;
            bsb_pkg::branch_same_or_higher:  branch_o = ~fc;
            bsb_pkg::branch_minus:           branch_o = fn;
            bsb_pkg::branch_plus:            branch_o = ~fn;
            bsb_pkg::branch_signed_ge:       branch_o = ~(fn ^ fv);
            bsb_pkg::branch_signed_lt:       branch_o = fn ^ fv;
            bsb_pkg::branch_half_carry_one:  branch_o = fh;
            bsb_pkg::branch_half_carry_zero: branch_o = ~fh;
            bsb_pkg::branch_transfer_one:    branch_o = ft;
            bsb_pkg::branch_transfer_zero:   branch_o = ~ft;
            bsb_pkg::branch_overflow_one:    branch_o = fv;
            bsb_pkg::branch_overflow_zero:   branch_o = ~fv;
            bsb_pkg::branch_irq_enabled:     branch_o = fi;
            bsb_pkg::branch_irq_disabled:    branch_o = ~fi;
            default:
            begin
                skip_o   = 1'b0;
                branch_o = 1'b0;
            end
        endcase
    end

endmodule

// ==== src/bsb_exec.sv ====
// Execution unit for bit skips, flag branches, I/O bit writes and shifts.
// Assumes the core fetch logic presents one instruction per request and
// holds operands stable on the request cycle; all on the core clock.
`timescale 1ns/1ns
module bsb_exec
(
    input  wire logic                        clock_i,
    input  wire logic                        resetn_i,
    input  wire logic                        start_i,
    input  wire logic [4:0]                  op_i,
    input  wire logic [2:0]                  bit_sel_i,
    input  wire logic [bsb_pkg::OFS_W-1:0]   offset_i,
    input  wire logic [bsb_pkg::PC_W-1:0]    pc_i,
    input  wire logic                        next_two_word_i,
    input  wire logic [bsb_pkg::DATA_W-1:0]  reg_data_i,
    input  wire logic [bsb_pkg::DATA_W-1:0]  io_data_i,
    input  wire logic [bsb_pkg::DATA_W-1:0]  status_word_i,
    output logic                             ready_o,
    output logic                             done_o,
    output logic [bsb_pkg::PC_W-1:0]         next_pc_o,
    output logic                             skip_o,
    output logic                             taken_o,
    output logic [bsb_pkg::DATA_W-1:0]       reg_wdata_o,
    output logic                             reg_we_o,
    output logic [bsb_pkg::DATA_W-1:0]       io_wdata_o,
    output logic                             io_we_o,
    output logic [bsb_pkg::DATA_W-1:0]       status_word_o,
    output logic                             status_we_o
);

    // ========================================
    // Reset release
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ========================================
    // Helpers
    function automatic logic [bsb_pkg::PC_W-1:0] pc_add(
        input logic [bsb_pkg::PC_W-1:0] base,
        input logic [bsb_pkg::PC_W-1:0] delta);
        pc_add = base + delta;
    endfunction

    function automatic logic [7:0] bit_write(input logic [7:0] v,
                                             input logic [2:0] b,
                                             input logic       val);
        logic [7:0] t;
        t      = v;
        t[b]   = val;
        bit_write = t;
    endfunction

    // ========================================
    // Condition evaluation
    logic cond_skip;
    logic cond_branch;

    bsb_cond u_cond
    (
        .op_i          (op_i),
        .bit_sel_i     (bit_sel_i),
        .reg_data_i    (reg_data_i),
        .io_data_i     (io_data_i),
        .status_word_i (status_word_i),
        .skip_o        (cond_skip),
        .branch_o      (cond_branch)
    );

    // ========================================
    // Operation result
    logic [bsb_pkg::PC_W-1:0]   ofs_ext;
    logic [bsb_pkg::PC_W-1:0]   res_pc;
    logic [bsb_pkg::CNT_W-1:0]  res_cyc;
    logic [bsb_pkg::DATA_W-1:0] res_reg;
    logic                       res_reg_we;
    logic [bsb_pkg::DATA_W-1:0] res_io;
    logic                       res_io_we;
    logic [bsb_pkg::DATA_W-1:0] res_sw;
    logic                       res_sw_we;
    logic                       shift_out;
    logic                       is_skip;
    logic                       is_branch;

    assign ofs_ext = {{(bsb_pkg::PC_W-bsb_pkg::OFS_W){offset_i[6]}},
                      offset_i};
    assign is_skip   = (op_i[4:2] == 3'b000);
    assign is_branch = ~is_skip & (op_i[4:3] != 2'b11);

    always_comb
    begin
        res_pc     = pc_add(pc_i, 10'h001);
        res_cyc    = bsb_pkg::CYC_PLAIN;
        res_reg    = reg_data_i;
        res_reg_we = 1'b0;
        res_io     = io_data_i;
        res_io_we  = 1'b0;
        res_sw     = status_word_i;
        res_sw_we  = 1'b0;
        shift_out  = 1'b0;
        if (is_skip)
        begin
            if (cond_skip && next_two_word_i)
            begin
                res_pc  = pc_add(pc_i, 10'h003);
                res_cyc = bsb_pkg::CYC_SKIP_TWO;
            end
            else if (cond_skip)
            begin
                res_pc  = pc_add(pc_i, 10'h002);
                res_cyc = bsb_pkg::CYC_SKIP_ONE;
            end
        end
        else if (is_branch)
        begin
            // target PC plus k plus one
            if (cond_branch)
            begin
                res_pc  = pc_add(pc_add(pc_i, ofs_ext), 10'h001);
                res_cyc = bsb_pkg::CYC_BR_TAKEN;
            end
        end
        else
        begin
            unique case (op_i)
                bsb_pkg::io_bit_force_one:
                begin
                    res_io    = bit_write(io_data_i, bit_sel_i, 1'b1);
                    res_io_we = 1'b1;
                    res_cyc   = bsb_pkg::CYC_IO_BIT;
                end
                bsb_pkg::io_bit_force_zero:
                begin
                    res_io    = bit_write(io_data_i, bit_sel_i, 1'b0);
                    res_io_we = 1'b1;
                    res_cyc   = bsb_pkg::CYC_IO_BIT;
                end
                bsb_pkg::logic_shift_up:
                begin
                    res_reg    = {reg_data_i[6:0], 1'b0};
                    shift_out  = reg_data_i[7];
                    res_reg_we = 1'b1;
                    res_cyc    = bsb_pkg::CYC_SHIFT;
                end
                bsb_pkg::logic_shift_down:
                begin
                    res_reg    = {1'b0, reg_data_i[7:1]};
                    shift_out  = reg_data_i[0];
                    res_reg_we = 1'b1;
                    res_cyc    = bsb_pkg::CYC_SHIFT;
                end
                default:
                begin
                    res_cyc = bsb_pkg::CYC_PLAIN;
                end
            endcase
            if (res_reg_we)
            begin
                res_sw[bsb_pkg::FLAG_C] = shift_out;
                res_sw[bsb_pkg::FLAG_Z] = (res_reg == 8'h00);
                res_sw[bsb_pkg::FLAG_N] = res_reg[7];
                res_sw[bsb_pkg::FLAG_V] = res_reg[7] ^ shift_out;
                res_sw_we               = 1'b1;
            end
        end
    end

    // ========================================
    // Sequencer
    bsb_pkg::bsb_state_type     state_r;
    bsb_pkg::bsb_state_type     state_nxt;
    logic [bsb_pkg::CNT_W-1:0]  remain_r;
    logic [bsb_pkg::CNT_W-1:0]  remain_nxt;
    logic                       accept;
    logic                       last;

    assign accept = start_i && (state_r == bsb_pkg::ST_IDLE);
    assign last   = (state_r == bsb_pkg::ST_RUN) && (remain_r == 2'h1);

    always_comb
    begin
        state_nxt  = state_r;
        remain_nxt = remain_r;
        unique case (state_r)
            bsb_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    state_nxt  = bsb_pkg::ST_RUN;
                    remain_nxt = res_cyc;
                end
            end
            bsb_pkg::ST_RUN:
            begin
                if (last)
                begin
                    state_nxt  = bsb_pkg::ST_IDLE;
                    remain_nxt = bsb_pkg::CNT_RST;
                end
                else
                begin
                    remain_nxt = remain_r - 2'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            state_r  <= bsb_pkg::ST_IDLE;
            remain_r <= bsb_pkg::CNT_RST;
        end
        else
        begin
            state_r  <= state_nxt;
            remain_r <= remain_nxt;
        end
    end

    // ========================================
    // Result registers
    logic [bsb_pkg::PC_W-1:0]   pc_r;
    logic [bsb_pkg::PC_W-1:0]   pc_nxt;
    logic                       skip_r;
    logic                       skip_nxt;
    logic                       taken_r;
    logic                       taken_nxt;
    logic [bsb_pkg::DATA_W-1:0] reg_r;
    logic [bsb_pkg::DATA_W-1:0] reg_nxt;
    logic                       reg_we_r;
    logic                       reg_we_nxt;
    logic [bsb_pkg::DATA_W-1:0] io_r;
    logic [bsb_pkg::DATA_W-1:0] io_nxt;
    logic                       io_we_r;
    logic                       io_we_nxt;
    logic [bsb_pkg::DATA_W-1:0] sw_r;
    logic [bsb_pkg::DATA_W-1:0] sw_nxt;
    logic                       sw_we_r;
    logic                       sw_we_nxt;

    always_comb
    begin
        pc_nxt     = pc_r;
        skip_nxt   = skip_r;
        taken_nxt  = taken_r;
        reg_nxt    = reg_r;
        reg_we_nxt = reg_we_r;
        io_nxt     = io_r;
        io_we_nxt  = io_we_r;
        sw_nxt     = sw_r;
        sw_we_nxt  = sw_we_r;
        if (accept)
        begin
            pc_nxt     = res_pc;
            skip_nxt   = is_skip & cond_skip;
            taken_nxt  = is_branch & cond_branch;
            reg_nxt    = res_reg;
            reg_we_nxt = res_reg_we;
            io_nxt     = res_io;
            io_we_nxt  = res_io_we;
            // skips and branches leave flags alone
            sw_nxt     = res_sw;
            sw_we_nxt  = res_sw_we;
        end
    end

    always_ff @(posedge clock_i or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            pc_r     <= bsb_pkg::PC_RST;
            skip_r   <= 1'b0;
            taken_r  <= 1'b0;
            reg_r    <= bsb_pkg::DATA_RST;
            reg_we_r <= 1'b0;
            io_r     <= bsb_pkg::DATA_RST;
            io_we_r  <= 1'b0;
            sw_r     <= bsb_pkg::DATA_RST;
            sw_we_r  <= 1'b0;
        end
        else
        begin
            pc_r     <= pc_nxt;
            skip_r   <= skip_nxt;
            taken_r  <= taken_nxt;
            reg_r    <= reg_nxt;
            reg_we_r <= reg_we_nxt;
            io_r     <= io_nxt;
            io_we_r  <= io_we_nxt;
            sw_r     <= sw_nxt;
            sw_we_r  <= sw_we_nxt;
        end
    end

    // ========================================
    // Outputs
    assign ready_o       = (state_r == bsb_pkg::ST_IDLE);
    assign done_o        = last;
    assign next_pc_o     = pc_r;
    assign skip_o        = skip_r;
    assign taken_o       = taken_r;
    assign reg_wdata_o   = reg_r;
    assign reg_we_o      = last & reg_we_r;
    assign io_wdata_o    = io_r;
    assign io_we_o       = last & io_we_r;
    assign status_word_o = sw_r;
    assign status_we_o   = last & sw_we_r;

endmodule

// ==== verification/bsb_exec_asserts.sv ====
// Checker for bsb_exec: timing, targets and results at the ports.
// Assumes one core clock; bound to every bsb_exec instance below.
`timescale 1ns/1ns
module bsb_exec_chk
(
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic       start_i,
    input wire logic [4:0] op_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [6:0] offset_i,
    input wire logic [9:0] pc_i,
    input wire logic       next_two_word_i,
    input wire logic [7:0] reg_data_i,
    input wire logic [7:0] io_data_i,
    input wire logic [7:0] status_word_i,
    input wire logic       ready_o,
    input wire logic       done_o,
    input wire logic [9:0] next_pc_o,
    input wire logic       skip_o,
    input wire logic       taken_o,
    input wire logic [7:0] reg_wdata_o,
    input wire logic       reg_we_o,
    input wire logic [7:0] io_wdata_o,
    input wire logic       io_we_o,
    input wire logic [7:0] status_word_o,
    input wire logic       status_we_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    // ========================================
    // Request capture and cycle counting
    logic [4:0] op_q;
    logic [9:0] pc_q;
    logic [9:0] tgt_q;
    logic [7:0] reg_q;
    logic [7:0] io_q;
    logic [7:0] sw_q;
    logic [2:0] bs_q;
    logic       two_q;
    logic [1:0] cyc_r;
    logic [1:0] exp_n;
    wire        acc     = start_i && ready_o;
    wire        is_skip = (op_q < 5'h04);
    wire        is_br   = (op_q >= 5'h04) && (op_q < 5'h18);
    wire        is_sh   = (op_q[4:1] == 4'hD);
    wire [7:0]  mask    = 8'h01 << bs_q;
    wire [7:0]  io_exp  = op_q[0] ? (io_q & ~mask) : (io_q | mask);

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cyc_r <= 2'h0;
        else if (acc)
            cyc_r <= 2'h1;
        else if (!ready_o)
            cyc_r <= cyc_r + 2'h1;
    end

    always_ff @(posedge clock_i)
    begin
        if (acc)
        begin
            op_q  <= op_i;
            pc_q  <= pc_i;
            tgt_q <= pc_i + {{3{offset_i[6]}}, offset_i} + 10'h001;
            reg_q <= reg_data_i;
            io_q  <= io_data_i;
            sw_q  <= status_word_i;
            bs_q  <= bit_sel_i;
            two_q <= next_two_word_i;
        end
    end

    always_comb
    begin
        exp_n = 2'h1;
        if (is_skip && skip_o)
            exp_n = two_q ? 2'h3 : 2'h2;
        if ((is_br && taken_o) || op_q[4:1] == 4'hC)
            exp_n = 2'h2;
    end

    // ========================================
    // Assertions
    chk_done_cycles: assert property (done_o |-> cyc_r == exp_n)
        else $error("done at wrong cycle count");
    chk_accept_done: assert property (acc |-> ##[1:3] done_o)
        else $error("request not completed in time");
    chk_ready_back: assert property (done_o |=> ready_o)
        else $error("not ready after done");
    chk_branch_target: assert property (done_o && is_br && taken_o
        |-> next_pc_o == tgt_q) else $error("bad branch target");
    chk_skip_target: assert property (done_o && is_skip && skip_o
        |-> next_pc_o == pc_q + (two_q ? 10'h003 : 10'h002))
        else $error("bad skip target");
    chk_io_write: assert property (io_we_o |-> done_o
        && io_wdata_o == io_exp) else $error("bad I/O bit write");
    chk_shift_up: assert property (done_o && op_q == 5'h1A
        |-> reg_we_o && reg_wdata_o == {reg_q[6:0], 1'b0}
        && status_word_o[0] == reg_q[7]) else $error("bad left shift");
    chk_shift_down: assert property (done_o && op_q == 5'h1B
        |-> reg_we_o && reg_wdata_o == {1'b0, reg_q[7:1]}
        && status_word_o[0] == reg_q[0]) else $error("bad right shift");
    chk_shift_flags: assert property (status_we_o |->
        status_word_o[1] == (reg_wdata_o == 8'h00)
        && status_word_o[2] == reg_wdata_o[7]
        && status_word_o[3] == (status_word_o[2] ^ status_word_o[0])
        && status_word_o[7:4] == sw_q[7:4]) else $error("bad shift flags");
    chk_flags_kept: assert property (done_o && !is_sh
        |-> !status_we_o && !reg_we_o) else $error("flags written");

    cover property (done_o && is_br && taken_o);
    cover property (done_o && skip_o && two_q);
    cover property (io_we_o);
    cover property (status_we_o && reg_wdata_o == 8'h00);
endmodule

bind bsb_exec bsb_exec_chk u_chk (.clock_i, .resetn_i, .start_i, .op_i,
    .bit_sel_i, .offset_i, .pc_i, .next_two_word_i, .reg_data_i, .io_data_i,
    .status_word_i, .ready_o, .done_o, .next_pc_o, .skip_o, .taken_o,
    .reg_wdata_o, .reg_we_o, .io_wdata_o, .io_we_o, .status_word_o,
    .status_we_o);

// ==== verification/tb_top.sv ====
// Self-checking bench for bsb_exec: drives requests, judges results.
// Assumes a 20 MHz core clock and one request at a time.
`timescale 1ns/1ns
module tb_top;
    logic       clock_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic       start_i = 1'b0;
    logic [4:0] op_i = 5'h00;
    logic [2:0] bit_sel_i = 3'h0;
    logic [6:0] offset_i = 7'h00;
    logic [9:0] pc_i = 10'h000;
    logic       next_two_word_i = 1'b0;
    logic [7:0] reg_data_i = 8'h00;
    logic [7:0] io_data_i = 8'h00;
    logic [7:0] status_word_i = 8'h00;
    logic ready_o, done_o, skip_o, taken_o, reg_we_o, io_we_o, status_we_o;
    logic [9:0] next_pc_o;
    logic [7:0] reg_wdata_o, io_wdata_o, status_word_o;
    int         err_count = 0;
    int         samples_checked = 0;
    int         cyc;

    bsb_exec u_dut (.clock_i, .resetn_i, .start_i, .op_i, .bit_sel_i,
        .offset_i, .pc_i, .next_two_word_i, .reg_data_i, .io_data_i,
        .status_word_i, .ready_o, .done_o, .next_pc_o, .skip_o, .taken_o,
        .reg_wdata_o, .reg_we_o, .io_wdata_o, .io_we_o, .status_word_o,
        .status_we_o);

    always #25 clock_i = ~clock_i;

    // ========================================
    // Shared tasks
    task automatic check(input string what, input logic [9:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One request; returns in the done cycle with cyc set to its length
    task automatic run(input logic [4:0] op, input logic [2:0] bs,
        input logic [6:0] ofs, input logic [9:0] pc, input logic two,
        input logic [7:0] rd, io, sw);
        @(posedge clock_i);
        op_i <= op;
        bit_sel_i <= bs;
        offset_i <= ofs;
        pc_i <= pc;
        next_two_word_i <= two;
        reg_data_i <= rd;
        io_data_i <= io;
        status_word_i <= sw;
        start_i <= 1'b1;
        @(posedge clock_i);
        start_i <= 1'b0;
        cyc = 0;
        repeat (6)
        begin
            #1;
            cyc++;
            if (done_o === 1'b1)
                return;
            @(posedge clock_i);
        end
        err_count++;
        report_and_stop();
    endtask

    function automatic logic br_cond(input logic [4:0] op,
        input logic [2:0] bs, input logic [7:0] sw);
        logic f;
        case (op[4:1])
            4'h2: f = sw[bs];
            4'h3: f = sw[1];
            4'h4: f = sw[0];
            4'h5: f = ~sw[0];
            4'h6: f = sw[2];
            4'h7: f = ~(sw[2] ^ sw[3]);
            4'h8: f = sw[5];
            4'h9: f = sw[6];
            4'hA: f = sw[3];
            default: f = sw[7];
        endcase
        return f ^ op[0];
    endfunction

    // ========================================
    // Scenarios
    task automatic t_reset;
        check("ready", ready_o, 1'h1);
        check("done", done_o, 1'h0);
        check("next_pc", next_pc_o, 10'h000);
    endtask

    task automatic t_branches;
        logic [7:0] sws [4] = '{8'h00, 8'hFF, 8'h14, 8'h6B};
        logic [2:0] bs;
        logic [6:0] k;
        logic [9:0] pc;
        logic       tk;
        for (int op = 4; op < 24; op++)
            for (int s = 0; s < 4; s++)
            begin
                bs = 3'(op + s);
                k = 7'(op * 9 + s * 31);
                pc = 10'h3F0 + 10'(op);
                tk = br_cond(5'(op), bs, sws[s]);
                run(5'(op), bs, k, pc, 1'b0, 8'h00, 8'h00, sws[s]);
                check("taken", taken_o, tk);
                check("cycles", 10'(cyc), tk ? 10'h002 : 10'h001);
                check("next_pc", next_pc_o, tk ?
                    pc + {{3{k[6]}}, k} + 10'h001 : pc + 10'h001);
                check("flags_we", status_we_o, 1'h0);
            end
    endtask

    task automatic t_skips;
        logic [7:0] src;
        logic       sk;
        logic [1:0] n;
        for (int op = 0; op < 4; op++)
            for (int b = 0; b < 16; b++)
            begin
                src = (op < 2) ? 8'hA6 : 8'h59;
                sk = src[b % 8] ^ ~op[0];
                n = sk ? (b > 7 ? 2'h3 : 2'h2) : 2'h1;
                run(5'(op), 3'(b), 7'h00, 10'h120, b > 7, 8'hA6, 8'h59, 8'h00);
                check("skip", skip_o, sk);
                check("cycles", 10'(cyc), 10'(n));
                check("next_pc", next_pc_o, 10'h120 + 10'(n));
                check("flags_we", status_we_o, 1'h0);
            end
    endtask

    task automatic t_io_bits;
        logic [7:0] m;
        for (int op = 24; op < 26; op++)
            for (int b = 0; b < 8; b++)
            begin
                m = 8'h01 << b;
                run(5'(op), 3'(b), 7'h00, 10'h000, 1'b0, 8'h00, 8'h5A, 8'h00);
                check("io_we", io_we_o, 1'h1);
                check("io_wdata", io_wdata_o,
                    op[0] ? (8'h5A & ~m) : (8'h5A | m));
                check("cycles", 10'(cyc), 10'h002);
                check("flags_we", status_we_o, 1'h0);
            end
    endtask

    task automatic t_shifts;
        logic [7:0] vals [5] = '{8'h81, 8'h80, 8'h01, 8'h00, 8'h7E};
        logic [7:0] r;
        logic       c;
        for (int op = 26; op < 28; op++)
            for (int i = 0; i < 5; i++)
            begin
                r = op[0] ? {1'b0, vals[i][7:1]} : {vals[i][6:0], 1'b0};
                c = op[0] ? vals[i][0] : vals[i][7];
                run(5'(op), 3'h0, 7'h00, 10'h000, 1'b0, vals[i], 8'h00, 8'hF5);
                check("result", reg_wdata_o, r);
                check("reg_we", reg_we_o, 1'h1);
                check("flags_we", status_we_o, 1'h1);
                check("cycles", 10'(cyc), 10'h001);
                check("flags", status_word_o, {4'hF, r[7] ^ c, r[7],
                    r == 8'h00, c});
            end
    endtask

    task automatic t_refused;
        int n = 0;
        @(posedge clock_i);
        op_i <= 5'h18;
        bit_sel_i <= 3'h0;
        io_data_i <= 8'h00;
        start_i <= 1'b1;
        @(posedge clock_i);
        for (int i = 0; i < 4; i++)
        begin
            #1;
            n += io_we_o;
            @(posedge clock_i);
            if (i == 1)
                start_i <= 1'b0;
        end
        check("io_writes", 10'(n), 10'h001);
        check("io_wdata", io_wdata_o, 8'h01);
        // Unused op code: one cycle, plain step, no writes
        run(5'h1C, 3'h0, 7'h05, 10'h010, 1'b1, 8'h00, 8'h00, 8'h00);
        check("cycles", 10'(cyc), 10'h001);
        check("next_pc", next_pc_o, 10'h011);
    endtask

    initial
    begin
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        t_reset();
        t_branches();
        t_skips();
        t_io_bits();
        t_shifts();
        t_refused();
        report_and_stop();
    end
endmodule
